/* verilog/cdhi_pkg.sv */
// Package for the cutter drive and head interlock controller.
// Assumes a 100 MHz clock and an AXI4-Lite master in front of the controller.
package cdhi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned TICK_US          = 1000;
  localparam int unsigned TICK_CYCLES      = TICK_US * CLK_MHZ;
  localparam int unsigned STOP_GAP_MS      = 1;
  localparam int unsigned CUT_NOMINAL_MS   = 400;
  localparam int unsigned CUT_TIMEOUT_MS   = 2 * CUT_NOMINAL_MS;
  localparam int unsigned BRAKE_MS         = 10;
  localparam int unsigned DEBOUNCE_MS      = 5;
  localparam int unsigned FEED_CUT_UM      = 11000;
  localparam int unsigned TEMP_LIMIT_C     = 65;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_BRAKE     = 8'h08;
  localparam logic [7:0] OFS_TIMEOUT   = 8'h0C;
  localparam logic [7:0] OFS_TEMP      = 8'h10;
  localparam logic [7:0] OFS_FEED      = 8'h14;

  // CTRL bits
  localparam int unsigned CTRL_PRINT   = 0;
  localparam int unsigned CTRL_CUT     = 1;
  localparam int unsigned CTRL_INIT    = 2;
  localparam int unsigned CTRL_CLRF    = 3;
  localparam int unsigned CTRL_GATE    = 4;

  localparam logic [15:0] BRAKE_RST    = 16'(BRAKE_MS);
  localparam logic [15:0] TIMEOUT_RST  = 16'(CUT_TIMEOUT_MS);
  localparam logic [7:0]  TEMP_RST     = 8'(TEMP_LIMIT_C);
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CDHI_DRV_STOP,
    CDHI_DRV_FWD,
    CDHI_DRV_REV,
    CDHI_DRV_BRAKE
  } cdhi_drive_t;

  typedef struct packed {
    logic paper_out;
    logic platen_open;
    logic paper_feeding;
    logic home_raw;
    logic [7:0] head_temp_c;
  } cdhi_sense_t;

  typedef struct packed {
    logic bridge_in_a;
    logic bridge_in_b;
    logic head_power_rail;
    logic logic_supply_en;
    logic heat_pulse_gate_n;
    logic feed_request;
  } cdhi_drive_out_t;

endpackage : cdhi_pkg

/* verilog/cdhi_debounce.sv */
// Debouncer for a chattering switch input.
// Assumes the input is synchronous to aclk and a 1 ms tick pulse.
`timescale 1ns/1ps
module cdhi_debounce #(
  parameter int unsigned STABLE_TICKS = cdhi_pkg::DEBOUNCE_MS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick,
  input  wire logic raw,
  output logic      clean
);
  logic [7:0] cnt_q;
  logic       clean_q;
  wire        differs = raw != clean_q;
  wire        settled = cnt_q >= 8'(STABLE_TICKS);

  assign clean = clean_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= 8'h00;
      clean_q <= 1'b0;
    end else if (!differs) begin
      cnt_q <= 8'h00;
    end else if (settled) begin
      clean_q <= raw;
      cnt_q   <= 8'h00;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : cdhi_debounce

/* verilog/cdhi_ctrl.sv */
// Cutter drive and thermal head interlock controller, AXI4-Lite slave.
// Assumes synchronous sense inputs and an external bridge, rail switches and head.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// How it works
// - Head strobe and rail drop at once when temperature exceeds the limit.
// - Logic supply rises before head rail; at reset both fall in the same cycle.
// - Heat pulse gate stays disabled when not printing or during power switching.
// - Head power rail stays off whenever no printing is in progress.
// - Forward drives bridge input A high, B low.
// - Reverse drives bridge input A low, B high.
// - Forward and reverse are never driven together.
// - Every drive change passes through at least 1 ms of stop.
// - Bridge encoding: forward HL, reverse LH, brake HH, stop LL.
// - Brake duration is a software register.
// - Home switch is debounced on both edges.
// - No cut starts or continues during feed or with platen open.
// - No cut runs when paper is out.
// - Head energizing is inhibited on paper out.
// - Lockup release stops, reverses to home, else stops at once.
// - Platen open inhibits head energizing and cutter operation.
module cdhi_ctrl #(
  parameter int unsigned TICK_CYCLES = cdhi_pkg::TICK_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire cdhi_pkg::cdhi_sense_t   sense,
  input  wire logic                    feed_done,
  output cdhi_pkg::cdhi_drive_out_t    drive
);

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] div_q;
  wire         tick = div_q == 32'(TICK_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) div_q <= 32'h0;
    else          div_q <= tick ? 32'h0 : div_q + 32'h1;
  end

  logic home;
  cdhi_debounce #(.STABLE_TICKS(cdhi_pkg::DEBOUNCE_MS)) u_home (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .raw     (sense.home_raw),
    .clean   (home)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        print_q, gate_q, lockup_q, overtemp_q, cut_req_q, init_req_q;
  logic [15:0] brake_q, timeout_q;
  logic [7:0]  temp_lim_q;
  logic [15:0] feed_um_q;
  logic [31:0] rdata_q;
  logic        bvalid_q, rvalid_q, bresp_err_q, rresp_err_q;

  wire hot       = sense.head_temp_c > temp_lim_q;
  wire wr_fire   = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire rd_fire   = s_axi_arvalid && !rvalid_q;
  wire wr_ctrl   = wr_fire && s_axi_awaddr == cdhi_pkg::OFS_CTRL && s_axi_wstrb[0];
  wire wr_brake  = wr_fire && s_axi_awaddr == cdhi_pkg::OFS_BRAKE;
  wire wr_tmo    = wr_fire && s_axi_awaddr == cdhi_pkg::OFS_TIMEOUT;
  wire wr_temp   = wr_fire && s_axi_awaddr == cdhi_pkg::OFS_TEMP;
  wire wr_feed   = wr_fire && s_axi_awaddr == cdhi_pkg::OFS_FEED;
  wire wr_ok     = wr_ctrl || wr_brake || wr_tmo || wr_temp || wr_feed
                   || (wr_fire && s_axi_awaddr == cdhi_pkg::OFS_STATUS);
  wire rd_ok     = s_axi_araddr <= cdhi_pkg::OFS_FEED && s_axi_araddr[1:0] == 2'b00;
  wire set_lock, cut_busy;

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_err_q ? cdhi_pkg::RESP_SLVERR : cdhi_pkg::RESP_OKAY;
  assign s_axi_arready = rd_fire;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_err_q ? cdhi_pkg::RESP_SLVERR : cdhi_pkg::RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      print_q    <= 1'b0;
      gate_q     <= 1'b0;
      cut_req_q  <= 1'b0;
      init_req_q <= 1'b0;
      brake_q    <= cdhi_pkg::BRAKE_RST;
      timeout_q  <= cdhi_pkg::TIMEOUT_RST;
      temp_lim_q <= cdhi_pkg::TEMP_RST;
      feed_um_q  <= 16'(cdhi_pkg::FEED_CUT_UM);
    end else begin
      cut_req_q  <= wr_ctrl && s_axi_wdata[cdhi_pkg::CTRL_CUT];
      init_req_q <= wr_ctrl && s_axi_wdata[cdhi_pkg::CTRL_INIT];
      if (wr_ctrl) begin
        print_q <= s_axi_wdata[cdhi_pkg::CTRL_PRINT];
        gate_q  <= s_axi_wdata[cdhi_pkg::CTRL_GATE];
      end
      if (wr_brake) brake_q <= s_axi_wdata[15:0];
      if (wr_tmo) timeout_q <= s_axi_wdata[15:0];
      if (wr_temp) temp_lim_q <= s_axi_wdata[7:0];
      if (wr_feed) feed_um_q <= s_axi_wdata[15:0];
    end
  end

  // Sticky faults, set wins over clear
  wire clr_f = wr_ctrl && s_axi_wdata[cdhi_pkg::CTRL_CLRF];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lockup_q   <= 1'b0;
      overtemp_q <= 1'b0;
    end else begin
      lockup_q   <= set_lock || (lockup_q && !clr_f);
      overtemp_q <= (print_q && hot) || (overtemp_q && !clr_f);
    end
  end

  // ----------------------------------------------------------------
  // Head power sequencing
  // ----------------------------------------------------------------
  logic       logic_q, rail_q, strobe_en_q;
  wire head_ok = print_q && !hot && !overtemp_q;
  wire head_allowed = head_ok && !sense.paper_out && !sense.platen_open;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      logic_q     <= 1'b0;
      rail_q      <= 1'b0;
      strobe_en_q <= 1'b0;
    end else begin
      logic_q <= 1'b1;
      rail_q  <= logic_q && head_allowed;
      // gate enabled only with rail settled
      strobe_en_q <= rail_q && head_allowed;
    end
  end
  assign drive.logic_supply_en   = logic_q;
  assign drive.head_power_rail   = rail_q && head_allowed;
  assign drive.heat_pulse_gate_n = !(strobe_en_q && head_allowed && gate_q);

  // ----------------------------------------------------------------
  // Cutter sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_FEED, ST_GAP, ST_RUN_OUT, ST_RUN_HOME, ST_BRAKE,
    ST_REL_STOP, ST_REL_REV
  } cdhi_cut_st_t;

  cdhi_cut_st_t          st_q, st_d, after_gap_q, after_gap_d;
  cdhi_pkg::cdhi_drive_t drv_q, drv_d;
  logic [15:0]           ms_q;
  logic                  ms_clr;
  logic                  lock_d;

  wire inhibit = sense.paper_feeding || sense.platen_open || sense.paper_out;
  // Two tick edges, so a stop never runs short of a full interval
  wire gap_done = ms_q > 16'(cdhi_pkg::STOP_GAP_MS);
  wire tmo      = ms_q >= timeout_q;

  always_comb begin
    st_d        = st_q;
    after_gap_d = after_gap_q;
    drv_d       = drv_q;
    ms_clr      = 1'b0;
    lock_d      = 1'b0;
    case (st_q)
      ST_IDLE: begin
        drv_d = cdhi_pkg::CDHI_DRV_STOP;
        // no start while feeding or open
        if (cut_req_q && !inhibit && !lockup_q) begin
          st_d = ST_FEED;
          ms_clr = 1'b1;
        end else if (init_req_q && !sense.platen_open && !lockup_q) begin
          st_d = ST_GAP;
          after_gap_d = home ? ST_IDLE : ST_RUN_HOME;
          ms_clr = 1'b1;
        end
      end
      ST_FEED: if (feed_done) begin
        st_d = ST_GAP;
        after_gap_d = ST_RUN_OUT;
        ms_clr = 1'b1;
      end
      ST_GAP: begin
        drv_d = cdhi_pkg::CDHI_DRV_STOP;
        if (gap_done) begin
          st_d = after_gap_q;
          ms_clr = 1'b1;
        end
      end
      // run until home leaves then returns
      ST_RUN_OUT, ST_RUN_HOME: begin
        drv_d = cdhi_pkg::CDHI_DRV_FWD;
        if (st_q == ST_RUN_OUT && !home) st_d = ST_RUN_HOME;
        if (st_q == ST_RUN_HOME && home) begin
          st_d = ST_GAP;
          after_gap_d = ST_BRAKE;
          ms_clr = 1'b1;
        end
        // abort on feed or platen open
        if (inhibit) begin
          st_d = ST_IDLE;
          drv_d = cdhi_pkg::CDHI_DRV_STOP;
        end
        else if (tmo) begin
          st_d = ST_REL_STOP;
          drv_d = cdhi_pkg::CDHI_DRV_STOP;
          lock_d = 1'b1;
          ms_clr = 1'b1;
        end
      end
      ST_BRAKE: begin
        drv_d = cdhi_pkg::CDHI_DRV_BRAKE;
        if (ms_q >= brake_q) begin
          st_d = ST_IDLE;
          drv_d = cdhi_pkg::CDHI_DRV_STOP;
        end
      end
      ST_REL_STOP: begin
        drv_d = cdhi_pkg::CDHI_DRV_STOP;
        if (gap_done) begin
          st_d = sense.platen_open ? ST_IDLE : ST_REL_REV;
          ms_clr = 1'b1;
        end
      end
      ST_REL_REV: begin
        drv_d = cdhi_pkg::CDHI_DRV_REV;
        // stop at home or at once
        if (home || tmo || sense.platen_open) begin
          st_d = ST_IDLE;
          drv_d = cdhi_pkg::CDHI_DRV_STOP;
        end
      end
      default: begin
        st_d = ST_IDLE;
        drv_d = cdhi_pkg::CDHI_DRV_STOP;
      end
    endcase
  end

  assign set_lock = lock_d;
  assign cut_busy = st_q != ST_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= ST_IDLE;
      after_gap_q <= ST_IDLE;
      drv_q       <= cdhi_pkg::CDHI_DRV_STOP;
      ms_q        <= 16'h0;
    end else begin
      st_q        <= st_d;
      after_gap_q <= after_gap_d;
      drv_q       <= drv_d;
      ms_q        <= ms_clr ? 16'h0 : (tick && ms_q != 16'hFFFF ? ms_q + 16'h1 : ms_q);
    end
  end

  // only one drive path at a time
  assign drive.bridge_in_a  = drv_q == cdhi_pkg::CDHI_DRV_FWD
                              || drv_q == cdhi_pkg::CDHI_DRV_BRAKE;
  assign drive.bridge_in_b  = drv_q == cdhi_pkg::CDHI_DRV_REV
                              || drv_q == cdhi_pkg::CDHI_DRV_BRAKE;
  assign drive.feed_request = st_q == ST_FEED;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  wire [31:0] status_w = {22'h0, drv_q, st_q, home, overtemp_q, lockup_q, cut_busy};
  wire [31:0] rd_mux =
    s_axi_araddr == cdhi_pkg::OFS_CTRL    ? {27'h0, gate_q, 3'h0, print_q} :
    s_axi_araddr == cdhi_pkg::OFS_STATUS  ? status_w :
    s_axi_araddr == cdhi_pkg::OFS_BRAKE   ? {16'h0, brake_q} :
    s_axi_araddr == cdhi_pkg::OFS_TIMEOUT ? {16'h0, timeout_q} :
    s_axi_araddr == cdhi_pkg::OFS_TEMP    ? {16'h0, sense.head_temp_c, temp_lim_q} :
    s_axi_araddr == cdhi_pkg::OFS_FEED    ? {16'h0, feed_um_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q    <= 1'b0;
      rvalid_q    <= 1'b0;
      bresp_err_q <= 1'b0;
      rresp_err_q <= 1'b0;
      rdata_q     <= 32'h0;
    end else begin
      if (wr_fire) begin
        bvalid_q    <= 1'b1;
        bresp_err_q <= !wr_ok;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q    <= 1'b1;
        rresp_err_q <= !rd_ok;
        rdata_q     <= rd_ok ? rd_mux : 32'h0;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : cdhi_ctrl

/* verif/cdhi_ctrl_checker.sv */
// Concurrent checks on the cutter drive and head interlock controller.
// Assumes binding to cdhi_ctrl; sees its ports only.
`timescale 1ns/1ps
module cdhi_ctrl_checker #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire cdhi_pkg::cdhi_sense_t     sense,
  input wire cdhi_pkg::cdhi_drive_out_t drive
);
  logic [1:0]  ab;
  logic        inh;
  logic [15:0] stop_q;
  assign ab  = {drive.bridge_in_a, drive.bridge_in_b};
  assign inh = sense.paper_out | sense.platen_open | sense.paper_feeding;
  // Length of the current stop interval
  always_ff @(posedge aclk) begin
    if (!aresetn || ab != 2'b00) stop_q <= 16'h0000;
    else if (stop_q != 16'hFFFF) stop_q <= stop_q + 16'h0001;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_temp_cut: assert property (
    sense.head_temp_c > 8'(cdhi_pkg::TEMP_LIMIT_C) |->
      !drive.head_power_rail && drive.heat_pulse_gate_n) else $error("head live when hot");
  a_supply_first: assert property (
    drive.head_power_rail |-> drive.logic_supply_en) else $error("rail without logic supply");
  a_gate_rail: assert property (
    !drive.heat_pulse_gate_n |-> drive.head_power_rail) else $error("gate open without rail");
  a_head_inhibit: assert property (
    sense.paper_out || sense.platen_open |-> !drive.head_power_rail && drive.heat_pulse_gate_n)
    else $error("head live while inhibited");
  a_cut_inhibit: assert property (
    inh [*2] |-> ab == 2'b00) else $error("motor driven while inhibited");
  a_stop_gap: assert property (
    $past(ab) == 2'b00 && ab != 2'b00 |-> stop_q >= 16'(TICK_CYCLES / 2))
    else $error("stop interval too short");
  a_no_direct: assert property (
    ab != 2'b00 && $past(ab) != 2'b00 |-> ab == $past(ab)) else $error("drive change without stop");
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_bready |=>
      s_axi_bvalid ##1 !s_axi_bvalid) else $error("write response timing");
  a_read_resp: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_rready |=> s_axi_rvalid ##1 !s_axi_rvalid)
    else $error("read response timing");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("write taken while response pending");
endmodule : cdhi_ctrl_checker

bind cdhi_ctrl cdhi_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_cdhi_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sense(sense), .drive(drive)
);

/* verif/cdhi_mech_model.sv */
// Printer mechanism model: paper feed, cutter blade and home switch.
// Assumes bridge and feed request from the controller, one clock.
`timescale 1ns/1ps
module cdhi_mech_model #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned CUT_MS      = 400,
  parameter int unsigned FEED_MS     = 2
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire cdhi_pkg::cdhi_drive_out_t drive,
  input  wire logic                      jam,
  output logic                           feed_done,
  output logic                           home_raw
);
  logic        home_q, home_p, fwd, rev;
  logic [2:0]  chat_q;
  int unsigned pos_q, feed_q;
  assign fwd = drive.bridge_in_a & ~drive.bridge_in_b;
  assign rev = ~drive.bridge_in_a & drive.bridge_in_b;
  // Switch bounces after every change
  assign home_raw = home_q ^ chat_q[1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {home_q, home_p} <= 2'b11;
      chat_q <= 3'h0;
      pos_q <= 0;
      feed_q <= 0;
      feed_done <= 1'b0;
    end else begin
      home_p <= home_q;
      chat_q <= (home_p != home_q) ? 3'h6 : chat_q - 3'(chat_q != 3'h0);
      feed_q <= drive.feed_request ? feed_q + 1 : 0;
      feed_done <= drive.feed_request && feed_q == FEED_MS * TICK_CYCLES;
      if (fwd) begin
        pos_q <= pos_q + 1;
        if (pos_q == 2 * TICK_CYCLES) home_q <= 1'b0;
        if (pos_q == CUT_MS * TICK_CYCLES && !jam) home_q <= 1'b1;
      end else if (rev) begin
        pos_q <= (pos_q > 1) ? pos_q - 1 : 0;
        if (pos_q <= 1) home_q <= 1'b1;
      end else if (home_q && !drive.bridge_in_a) pos_q <= 0;
    end
  end
endmodule : cdhi_mech_model

/* verif/cutter_drive_head_interlock_test.sv */
// Testbench for the cutter drive and head interlock controller.
// Assumes the mechanism model and the bound checker.
`timescale 1ns/1ps
module cutter_drive_head_interlock_test;
  localparam int unsigned TICK = 10;
  localparam int unsigned CEIL = 30000;
  localparam logic [7:0]  OFS[4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
  localparam logic [31:0] RSTV[4] = '{32'(cdhi_pkg::BRAKE_MS), 32'(cdhi_pkg::CUT_TIMEOUT_MS),
    {16'h0000, 8'h19, 8'(cdhi_pkg::TEMP_LIMIT_C)}, 32'(cdhi_pkg::FEED_CUT_UM)};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, jam;
  logic        awready, wready, bvalid, arready, rvalid, feed_done, home_raw;
  logic        p_out, p_open, p_feed;
  logic [7:0]  awaddr, araddr, temp;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          num_errors, n_tests, cyc, n;
  cdhi_pkg::cdhi_sense_t     sense;
  cdhi_pkg::cdhi_drive_out_t drive;
  assign sense = {p_out, p_open, p_feed, home_raw, temp};

  cdhi_ctrl #(.TICK_CYCLES(TICK)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sense(sense), .feed_done(feed_done), .drive(drive)
  );
  cdhi_mech_model #(.TICK_CYCLES(TICK)) u_mech (
    .aclk(aclk), .aresetn(aresetn), .drive(drive), .jam(jam), .feed_done(feed_done),
    .home_raw(home_raw)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task summarize;
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    {rd, rsp} = {rdata, rresp};
    rready <= 1'b0;
  endtask : axi_rd

  task wait_ab(input logic a, input logic b, input int lim);
    n = 0;
    while (!(drive.bridge_in_a === a && drive.bridge_in_b === b) && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk_bit(n < lim, 1'b1);
  endtask : wait_ab

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, jam, p_out, p_open, p_feed} = '0;
    {awaddr, araddr, wdata, wstrb, temp} = {52'h0, 8'h19};
    {num_errors, n_tests, cyc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_bit(drive.logic_supply_en, 1'b1);
    for (int i = 0; i < 4; i++) begin
      axi_rd(OFS[i]);
      chk_word(rd, RSTV[i]);
    end
    axi_rd(8'h40);
    chk_word({rd[31:2], rsp}, {30'h0, cdhi_pkg::RESP_SLVERR});
    axi_wr(8'h40, 32'h0000_00FF);
    chk_word({30'h0, rsp}, {30'h0, cdhi_pkg::RESP_SLVERR});
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0011);
    repeat (4) @(posedge aclk);
    chk_word({drive.head_power_rail, drive.heat_pulse_gate_n}, 32'h2);
    temp <= 8'h46;
    repeat (2) @(posedge aclk);
    chk_bit(drive.head_power_rail, 1'b0);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_bit(rd[2], 1'b1);
    temp <= 8'h19;
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0019);
    repeat (4) @(posedge aclk);
    chk_bit(drive.head_power_rail, 1'b1);
    p_out <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_word({drive.head_power_rail, drive.heat_pulse_gate_n}, 32'h1);
    {p_out, p_open} <= 2'b01;
    repeat (2) @(posedge aclk);
    chk_word({drive.head_power_rail, drive.heat_pulse_gate_n}, 32'h1);
    p_open <= 1'b0;
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    chk_word({drive.head_power_rail, drive.heat_pulse_gate_n}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      {p_out, p_open, p_feed} <= 3'b001 << i;
      axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0002);
      repeat (30) @(posedge aclk);
      axi_rd(cdhi_pkg::OFS_STATUS);
      chk_word({rd[0], drive.bridge_in_a, drive.bridge_in_b}, 32'h0);
    end
    {p_out, p_open, p_feed} <= 3'b000;
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0004);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_word(rd & 32'h0000_0309, 32'h0000_0009);
    repeat (30) @(posedge aclk);
    axi_wr(cdhi_pkg::OFS_BRAKE, 32'h0000_0003);
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk_bit(drive.feed_request, 1'b1);
    wait_ab(1'b1, 1'b0, 200);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_word(rd & 32'h0000_0301, 32'h0000_0101);
    wait_ab(1'b1, 1'b1, 6000);
    n = 0;
    while (drive.bridge_in_a && drive.bridge_in_b && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk_bit(n >= 2 * TICK && n <= 4 * TICK, 1'b1);
    repeat (5) @(posedge aclk);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_bit(rd[0], 1'b0);
    axi_wr(cdhi_pkg::OFS_TIMEOUT, 32'h0000_000F);
    jam <= 1'b1;
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0002);
    wait_ab(1'b0, 1'b1, 400);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_bit(rd[1], 1'b1);
    wait_ab(1'b0, 1'b0, 400);
    jam <= 1'b0;
    repeat (20) @(posedge aclk);
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (30) @(posedge aclk);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_word(rd & 32'h0000_0003, 32'h0000_0002);
    axi_wr(cdhi_pkg::OFS_CTRL, 32'h0000_0008);
    axi_rd(cdhi_pkg::OFS_STATUS);
    chk_bit(rd[1], 1'b0);
    summarize();
  end
endmodule : cutter_drive_head_interlock_test
